// [core/lane_cfg_pkg.sv]
package lane_cfg_pkg;

    // ====================================================================
    // management space
    localparam logic [4:0] MGMT_DEV = 5'h1e;
    localparam logic [15:0] LANE_CTRL_B_ADDR = 16'h0007;
    localparam logic [15:0] LANE_CTRL_C_ADDR = 16'h0008;
    localparam logic [15:0] LANE_CTRL_B_RST = 16'hdc04;
    localparam logic [15:0] LANE_CTRL_C_RST = 16'h000d;
    localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;

    // ====================================================================
    // field positions, control register b
    localparam int SWING_HI = 14;
    localparam int SWING_LO = 12;
    localparam int LOS_EN_BIT = 11;
    localparam int TX_EN_BIT = 10;
    localparam int TX_RATE_HI = 9;
    localparam int TX_RATE_LO = 8;
    localparam int DEEMPH_HI = 7;
    localparam int DEEMPH_LO = 4;
    localparam int RX_EN_BIT = 2;
    localparam int RX_RATE_HI = 1;
    localparam int RX_RATE_LO = 0;

    // field positions, control register c
    localparam int RX_INV_BIT = 15;
    localparam int TX_INV_BIT = 14;
    localparam int EQ_HI = 11;
    localparam int EQ_LO = 8;

    localparam int NUM_LANES = 4;

    // ====================================================================
    // rate codes as written by software
    localparam logic [1:0] RATE_CODE_FULL = 2'h0;
    localparam logic [1:0] RATE_CODE_HALF = 2'h1;
    localparam logic [1:0] RATE_CODE_QUARTER = 2'h2;

    typedef enum logic [1:0] {
        RATE_FULL,
        RATE_HALF,
        RATE_QUARTER
    } rate_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } mgmt_rsp_t;

    // ====================================================================
    // typical swing in mV and de-emphasis in hundredths of a percent
    localparam logic [10:0] SWING_MV [8] = '{
        11'd190, 11'd380, 11'd560, 11'd710, 11'd850, 11'd950, 11'd1010, 11'd1050};
    localparam logic [12:0] DEEMPH_CPCT [16] = '{
        13'd0, 13'd476, 13'd952, 13'd1428, 13'd1904, 13'd2380, 13'd2856, 13'd3332,
        13'd3808, 13'd4285, 13'd4761, 13'd5238, 13'd5714, 13'd6190, 13'd6666, 13'd7142};

    // reserved code 11 falls back to full rate
    function automatic rate_t decode_rate(input logic [1:0] code);
        unique case (code)
            RATE_CODE_HALF: decode_rate = RATE_HALF;
            RATE_CODE_QUARTER: decode_rate = RATE_QUARTER;
            default: decode_rate = RATE_FULL;
        endcase
    endfunction

    function automatic logic hit(input mgmt_req_t r, input logic [15:0] a);
        hit = (r.dev == MGMT_DEV) && (r.addr == a);
    endfunction

endpackage

// [core/lane_rate_pick.sv]
`timescale 1ns/1ps
`default_nettype none

module lane_rate_pick (
    input wire logic [1:0] written_code,
    input wire lane_cfg_pkg::rate_t auto_rate,
    input wire logic manual,
    output lane_cfg_pkg::rate_t eff_rate
);
    import lane_cfg_pkg::*;

    // ====================================================================
    // the written field is ignored until manual is asserted, by the refclk rate select pin or the rate override
    always_comb begin
        eff_rate = manual ? decode_rate(written_code) : auto_rate;
    end

endmodule // lane_rate_pick

`default_nettype wire

// [core/low_speed_serdes_lane_config.sv]
`timescale 1ns/1ps
`default_nettype none

module low_speed_serdes_lane_config (
    input wire logic clk,
    input wire logic rst,
    input wire lane_cfg_pkg::mgmt_req_t mgmt_req,
    output lane_cfg_pkg::mgmt_rsp_t mgmt_rsp,
    input wire logic channel_powerdown_n,
    input wire logic global_powerdown,
    input wire logic refclk_rate_select_hi,
    input wire logic rate_override,
    input wire lane_cfg_pkg::rate_t auto_tx_rate,
    input wire lane_cfg_pkg::rate_t auto_rx_rate,
    input wire logic [3:0] rx_lane_data,
    input wire logic [3:0] tx_in_pos,
    input wire logic [3:0] tx_in_neg,
    output logic [3:0] rx_out_pos,
    output logic [3:0] rx_out_neg,
    output logic [3:0] tx_lane_data,
    output logic tx_lane_enable,
    output logic rx_lane_enable,
    output lane_cfg_pkg::rate_t tx_lane_rate,
    output lane_cfg_pkg::rate_t rx_lane_rate,
    output logic [2:0] output_swing_sel,
    output logic [10:0] swing_mv,
    output logic signal_loss_detect_en,
    output logic [3:0] tx_deemphasis_sel,
    output logic [12:0] deemph_cpct,
    output logic [3:0] rx_equalizer_sel
);
    import lane_cfg_pkg::*;

    // ====================================================================
    // register bank
    logic [15:0] ctrl_b_q, ctrl_b_d;
    logic [15:0] ctrl_c_q, ctrl_c_d;
    mgmt_rsp_t rsp_d;

    always_comb begin
        ctrl_b_d = ctrl_b_q;
        ctrl_c_d = ctrl_c_q;
        rsp_d.valid = mgmt_req.rd;
        rsp_d.rdata = UNMAPPED_RDATA;
        // whole word written, reserved bits included, so software must preserve them
        if (mgmt_req.wr && hit(mgmt_req, LANE_CTRL_B_ADDR)) begin
            ctrl_b_d = mgmt_req.wdata;
        end
        if (mgmt_req.wr && hit(mgmt_req, LANE_CTRL_C_ADDR)) begin
            ctrl_c_d = mgmt_req.wdata;
        end
        if (mgmt_req.rd && hit(mgmt_req, LANE_CTRL_B_ADDR)) begin
            rsp_d.rdata = ctrl_b_q;
        end else if (mgmt_req.rd && hit(mgmt_req, LANE_CTRL_C_ADDR)) begin
            rsp_d.rdata = ctrl_c_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_b_q <= LANE_CTRL_B_RST;
            ctrl_c_q <= LANE_CTRL_C_RST;
            mgmt_rsp <= '0;
        end else begin
            ctrl_b_q <= ctrl_b_d;
            ctrl_c_q <= ctrl_c_d;
            mgmt_rsp <= rsp_d;
        end
    end

    // ====================================================================
    // lane control
    logic manual_rate;
    rate_t tx_pick, rx_pick;
    logic powered_down;

    assign manual_rate = refclk_rate_select_hi | rate_override;
    // power-down overrides the stored enables without altering them
    assign powered_down = ~channel_powerdown_n | global_powerdown;

    lane_rate_pick u_tx_rate (
        .written_code(ctrl_b_q[TX_RATE_HI:TX_RATE_LO]),
        .auto_rate(auto_tx_rate),
        .manual(manual_rate),
        .eff_rate(tx_pick)
    );

    lane_rate_pick u_rx_rate (
        .written_code(ctrl_b_q[RX_RATE_HI:RX_RATE_LO]),
        .auto_rate(auto_rx_rate),
        .manual(manual_rate),
        .eff_rate(rx_pick)
    );

    logic tx_en_d, rx_en_d;
    logic [2:0] swing_d;
    logic [10:0] swing_mv_d;
    logic [3:0] deemph_d;
    logic [12:0] deemph_cpct_d;
    logic [3:0] rx_pos_d, rx_neg_d, tx_data_d;
    logic los_d;
    logic [3:0] eq_d;

    always_comb begin
        tx_en_d = ctrl_b_q[TX_EN_BIT] & ~powered_down;
        rx_en_d = ctrl_b_q[RX_EN_BIT] & ~powered_down;
        swing_d = ctrl_b_q[SWING_HI:SWING_LO];
        swing_mv_d = SWING_MV[swing_d];
        deemph_d = ctrl_b_q[DEEMPH_HI:DEEMPH_LO];
        deemph_cpct_d = DEEMPH_CPCT[deemph_d];
        los_d = ctrl_b_q[LOS_EN_BIT];
        eq_d = ctrl_c_q[EQ_HI:EQ_LO];
        // swap is a pin exchange, so both legs stay complementary
        rx_pos_d = ctrl_c_q[RX_INV_BIT] ? ~rx_lane_data : rx_lane_data;
        rx_neg_d = ~rx_pos_d;
        tx_data_d = ctrl_c_q[TX_INV_BIT] ? tx_in_neg : tx_in_pos;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_lane_enable <= 1'b0;
            rx_lane_enable <= 1'b0;
            tx_lane_rate <= RATE_FULL;
            rx_lane_rate <= RATE_FULL;
            output_swing_sel <= 3'h0;
            swing_mv <= 11'h0;
            signal_loss_detect_en <= 1'b0;
            tx_deemphasis_sel <= 4'h0;
            deemph_cpct <= 13'h0;
            rx_equalizer_sel <= 4'h0;
            rx_out_pos <= 4'h0;
            rx_out_neg <= 4'hf;
            tx_lane_data <= 4'h0;
        end else begin
            tx_lane_enable <= tx_en_d;
            rx_lane_enable <= rx_en_d;
            tx_lane_rate <= tx_pick;
            rx_lane_rate <= rx_pick;
            output_swing_sel <= swing_d;
            swing_mv <= swing_mv_d;
            signal_loss_detect_en <= los_d;
            tx_deemphasis_sel <= deemph_d;
            deemph_cpct <= deemph_cpct_d;
            rx_equalizer_sel <= eq_d;
            rx_out_pos <= rx_pos_d;
            rx_out_neg <= rx_neg_d;
            tx_lane_data <= tx_data_d;
        end
    end

    // ====================================================================
    // checks
    a_reset_defaults: assert property (@(posedge clk) rst |=>
        ctrl_b_q == LANE_CTRL_B_RST && ctrl_c_q == LANE_CTRL_C_RST)
        else $error("control registers not at reset values");

    a_write_b_lands: assert property (@(posedge clk) disable iff (rst)
        (mgmt_req.wr && mgmt_req.dev == MGMT_DEV && mgmt_req.addr == LANE_CTRL_B_ADDR)
        |=> ctrl_b_q == $past(mgmt_req.wdata))
        else $error("write to register b lost");

    a_read_c_data: assert property (@(posedge clk) disable iff (rst)
        (mgmt_req.rd && mgmt_req.dev == MGMT_DEV && mgmt_req.addr == LANE_CTRL_C_ADDR)
        |=> mgmt_rsp.valid && mgmt_rsp.rdata == $past(ctrl_c_q))
        else $error("read of register c wrong");

    a_tx_pd_force: assert property (@(posedge clk) disable iff (rst)
        (!channel_powerdown_n || global_powerdown) |=> !tx_lane_enable)
        else $error("tx lane enabled while powered down");

    a_rx_lane_follow: assert property (@(posedge clk) disable iff (rst)
        (!rst && channel_powerdown_n && !global_powerdown) |=> rx_lane_enable == $past(ctrl_b_q[RX_EN_BIT]))
        else $error("rx lane enable not following register");

    a_rate_auto_used: assert property (@(posedge clk) disable iff (rst)
        (!rst && !(refclk_rate_select_hi || rate_override)) |=> tx_lane_rate == $past(auto_tx_rate)
        && rx_lane_rate == $past(auto_rx_rate))
        else $error("written rate applied without override");

    a_rate_quarter: assert property (@(posedge clk) disable iff (rst)
        (!rst && rate_override && ctrl_b_q[TX_RATE_HI:TX_RATE_LO] == RATE_CODE_QUARTER)
        |=> tx_lane_rate == RATE_QUARTER)
        else $error("tx quarter rate not decoded");

    a_swing_table: assert property (@(posedge clk) disable iff (rst)
        (output_swing_sel == 3'h7) |-> swing_mv == 11'd1050)
        else $error("swing amplitude mismatch");

    a_rx_swap_pins: assert property (@(posedge clk) disable iff (rst)
        ctrl_c_q[RX_INV_BIT] |=> rx_out_pos == ~$past(rx_lane_data) && rx_out_neg == $past(rx_lane_data))
        else $error("rx pins not swapped");

    a_tx_invert_pair: assert property (@(posedge clk) disable iff (rst)
        ctrl_c_q[TX_INV_BIT] |=> tx_lane_data == $past(tx_in_neg))
        else $error("tx pair not inverted");

    a_eq_follow: assert property (@(posedge clk) disable iff (rst)
        !rst |=> rx_equalizer_sel == $past(ctrl_c_q[EQ_HI:EQ_LO]))
        else $error("equalizer field not applied");

    // antecedents other than a_rx_pd_force sample rst, so the reset edge never seeds a check on reset-valued outputs
    a_swing_follow: assert property (@(posedge clk) disable iff (rst)
        !rst |=> output_swing_sel == $past(ctrl_b_q[SWING_HI:SWING_LO]))
        else $error("swing select not applied");

    a_swing_min: assert property (@(posedge clk) disable iff (rst)
        (!rst ##1 (output_swing_sel == 3'h0)) |-> swing_mv == 11'd190)
        else $error("lowest swing amplitude wrong");

    a_swing_mid: assert property (@(posedge clk) disable iff (rst)
        (!rst ##1 (output_swing_sel == 3'h5)) |-> swing_mv == 11'd950)
        else $error("default swing amplitude wrong");

    a_los_follow: assert property (@(posedge clk) disable iff (rst)
        !rst |=> signal_loss_detect_en == $past(ctrl_b_q[LOS_EN_BIT]))
        else $error("loss detect enable not applied");

    a_tx_lane_follow: assert property (@(posedge clk) disable iff (rst)
        (!rst && channel_powerdown_n && !global_powerdown) |=> tx_lane_enable == $past(ctrl_b_q[TX_EN_BIT]))
        else $error("tx lane enable not following register");

    a_rx_pd_force: assert property (@(posedge clk) disable iff (rst)
        (!channel_powerdown_n || global_powerdown) |=> !rx_lane_enable)
        else $error("rx lane enabled while powered down");

    a_tx_rate_half: assert property (@(posedge clk) disable iff (rst)
        (!rst && (refclk_rate_select_hi || rate_override) && ctrl_b_q[TX_RATE_HI:TX_RATE_LO] == RATE_CODE_HALF)
        |=> tx_lane_rate == RATE_HALF)
        else $error("tx half rate not decoded");

    a_tx_rate_full: assert property (@(posedge clk) disable iff (rst)
        (!rst && (refclk_rate_select_hi || rate_override) && ctrl_b_q[TX_RATE_HI:TX_RATE_LO] == RATE_CODE_FULL)
        |=> tx_lane_rate == RATE_FULL)
        else $error("tx full rate not decoded");

    a_rx_rate_half: assert property (@(posedge clk) disable iff (rst)
        (!rst && (refclk_rate_select_hi || rate_override) && ctrl_b_q[RX_RATE_HI:RX_RATE_LO] == RATE_CODE_HALF)
        |=> rx_lane_rate == RATE_HALF)
        else $error("rx half rate not decoded");

    a_rx_rate_quarter: assert property (@(posedge clk) disable iff (rst)
        (!rst && (refclk_rate_select_hi || rate_override) && ctrl_b_q[RX_RATE_HI:RX_RATE_LO] == RATE_CODE_QUARTER)
        |=> rx_lane_rate == RATE_QUARTER)
        else $error("rx quarter rate not decoded");

    a_rx_rate_full: assert property (@(posedge clk) disable iff (rst)
        (!rst && (refclk_rate_select_hi || rate_override) && ctrl_b_q[RX_RATE_HI:RX_RATE_LO] == RATE_CODE_FULL)
        |=> rx_lane_rate == RATE_FULL)
        else $error("rx full rate not decoded");

    a_deemph_follow: assert property (@(posedge clk) disable iff (rst)
        !rst |=> tx_deemphasis_sel == $past(ctrl_b_q[DEEMPH_HI:DEEMPH_LO]))
        else $error("de-emphasis select not applied");

    a_deemph_none: assert property (@(posedge clk) disable iff (rst)
        (!rst ##1 (tx_deemphasis_sel == 4'h0)) |-> deemph_cpct == 13'd0)
        else $error("de-emphasis not zero at code 0");

    a_deemph_max: assert property (@(posedge clk) disable iff (rst)
        (!rst ##1 (tx_deemphasis_sel == 4'hf)) |-> deemph_cpct == 13'd7142)
        else $error("de-emphasis wrong at top code");

    a_rx_pins_normal: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ctrl_c_q[RX_INV_BIT]) |=> rx_out_pos == $past(rx_lane_data) && rx_out_neg == ~$past(rx_lane_data))
        else $error("rx pins swapped while normal");

    a_tx_pair_normal: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ctrl_c_q[TX_INV_BIT]) |=> tx_lane_data == $past(tx_in_pos))
        else $error("tx pair inverted while normal");

    a_read_b_data: assert property (@(posedge clk) disable iff (rst)
        (!rst && mgmt_req.rd && hit(mgmt_req, LANE_CTRL_B_ADDR))
        |=> mgmt_rsp.valid && mgmt_rsp.rdata == $past(ctrl_b_q))
        else $error("read of register b wrong");

    a_read_valid_pulse: assert property (@(posedge clk) disable iff (rst)
        (!rst && !mgmt_req.rd) |=> !mgmt_rsp.valid)
        else $error("read response without request");

    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
        (!rst && mgmt_req.rd && !hit(mgmt_req, LANE_CTRL_B_ADDR) && !hit(mgmt_req, LANE_CTRL_C_ADDR))
        |=> mgmt_rsp.valid && mgmt_rsp.rdata == UNMAPPED_RDATA)
        else $error("unmapped read returned data");

    a_hold_b: assert property (@(posedge clk) disable iff (rst)
        (!rst && !(mgmt_req.wr && hit(mgmt_req, LANE_CTRL_B_ADDR))) |=> $stable(ctrl_b_q))
        else $error("register b changed without write");

    a_write_c_lands: assert property (@(posedge clk) disable iff (rst)
        (!rst && mgmt_req.wr && hit(mgmt_req, LANE_CTRL_C_ADDR))
        |=> ctrl_c_q == $past(mgmt_req.wdata))
        else $error("write to register c lost");

    a_hold_c: assert property (@(posedge clk) disable iff (rst)
        (!rst && !(mgmt_req.wr && hit(mgmt_req, LANE_CTRL_C_ADDR))) |=> $stable(ctrl_c_q))
        else $error("register c changed without write");

endmodule // low_speed_serdes_lane_config

`default_nettype wire

// [verif/low_speed_serdes_lane_config_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module low_speed_serdes_lane_config_tb_top;
    import lane_cfg_pkg::*;

    // ====================================================================
    // stimulus, observation and bookkeeping
    logic clk = 1'b0;
    logic rst = 1'b1;
    mgmt_req_t mgmt_req = '0;
    mgmt_rsp_t mgmt_rsp;
    logic channel_powerdown_n = 1'b1;
    logic global_powerdown = 1'b0;
    logic refclk_rate_select_hi = 1'b0;
    logic rate_override = 1'b0;
    rate_t auto_tx_rate = RATE_FULL;
    rate_t auto_rx_rate = RATE_FULL;
    logic [3:0] rx_lane_data = 4'h0;
    logic [3:0] tx_in_pos = 4'h0;
    logic [3:0] tx_in_neg = 4'h0;
    logic [3:0] rx_out_pos, rx_out_neg, tx_lane_data, tx_deemphasis_sel, rx_equalizer_sel;
    logic tx_lane_enable, rx_lane_enable, signal_loss_detect_en;
    rate_t tx_lane_rate, rx_lane_rate;
    logic [2:0] output_swing_sel;
    logic [10:0] swing_mv;
    logic [12:0] deemph_cpct;
    int error_cnt = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;

    low_speed_serdes_lane_config uut (.clk, .rst, .mgmt_req, .mgmt_rsp, .channel_powerdown_n,
        .global_powerdown, .refclk_rate_select_hi, .rate_override, .auto_tx_rate, .auto_rx_rate,
        .rx_lane_data, .tx_in_pos, .tx_in_neg, .rx_out_pos, .rx_out_neg, .tx_lane_data,
        .tx_lane_enable, .rx_lane_enable, .tx_lane_rate, .rx_lane_rate, .output_swing_sel,
        .swing_mv, .signal_loss_detect_en, .tx_deemphasis_sel, .deemph_cpct, .rx_equalizer_sel);

    // ====================================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle request pulse, launched and dropped on rising edges
    task automatic access(input logic w, input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        mgmt_req <= '{wr: w, rd: !w, dev: dev, addr: a, wdata: d};
        @(posedge clk);
        mgmt_req <= '0;
        #1;
    endtask

    task automatic rd(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] exp);
        access(1'b0, dev, a, 16'h0000);
        chk(16'(mgmt_rsp.valid), 16'h0001);
        chk(mgmt_rsp.rdata, exp);
    endtask

    // register lands one edge after the write, lane outputs one edge later
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        access(1'b1, 5'h1e, a, d);
        settle();
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ====================================================================
    // scenarios
    task automatic t_reset();
        rd(5'h1e, 16'h0007, 16'hdc04);
        rd(5'h1e, 16'h0008, 16'h000d);
        chk(16'(output_swing_sel), 16'h0005);
        chk(16'(signal_loss_detect_en), 16'h0001);
        chk(16'(tx_lane_enable), 16'h0001);
        chk(16'(rx_lane_enable), 16'h0001);
        chk(16'(tx_lane_rate), 16'(RATE_FULL));
        chk(16'(rx_lane_rate), 16'(RATE_FULL));
        chk(16'(tx_deemphasis_sel), 16'h0000);
        chk(16'(rx_equalizer_sel), 16'h0000);
    endtask

    task automatic t_swing();
        logic [10:0] prev;
        logic [3:0] de;
        prev = '0;
        for (int c = 0; c < 8; c++) begin
            de = 4'(2 * c + 1);
            wr(16'h0007, {1'b1, 3'(c), 4'h4, de, 4'h4});
            chk(16'(output_swing_sel), 16'(c));
            if (c == 0) chk(16'(swing_mv), 16'd190);
            if (c == 7) chk(16'(swing_mv), 16'd1050);
            if (c > 0) chk(16'(swing_mv > prev), 16'h0001);
            prev = swing_mv;
            chk(16'(tx_deemphasis_sel), 16'(de));
            // table steps round, so allow a few hundredths above 4.76 per code
            chk(16'((deemph_cpct - 13'(476 * de)) < 4), 16'h0001);
            rd(5'h1e, 16'h0007, {1'b1, 3'(c), 4'h4, de, 4'h4});
        end
        wr(16'h0007, 16'hd404);
        chk(16'(signal_loss_detect_en), 16'h0000);
        wr(16'h0007, 16'hdc04);
    endtask

    task automatic t_enable();
        wr(16'h0007, 16'hd804);
        chk({tx_lane_enable, rx_lane_enable}, 16'h0001);
        wr(16'h0007, 16'hdc00);
        chk({tx_lane_enable, rx_lane_enable}, 16'h0002);
        wr(16'h0007, 16'hdc04);
        @(posedge clk) channel_powerdown_n <= 1'b0;
        settle();
        chk({tx_lane_enable, rx_lane_enable}, 16'h0000);
        rd(5'h1e, 16'h0007, 16'hdc04);
        @(posedge clk) {channel_powerdown_n, global_powerdown} <= 2'b11;
        settle();
        chk({tx_lane_enable, rx_lane_enable}, 16'h0000);
        @(posedge clk) global_powerdown <= 1'b0;
        settle();
        chk({tx_lane_enable, rx_lane_enable}, 16'h0003);
    endtask

    task automatic t_rate();
        @(posedge clk);
        auto_tx_rate <= RATE_QUARTER;
        auto_rx_rate <= RATE_HALF;
        wr(16'h0007, 16'hdd06);
        chk({tx_lane_rate, rx_lane_rate}, {12'h0, RATE_QUARTER, RATE_HALF});
        @(posedge clk) refclk_rate_select_hi <= 1'b1;
        settle();
        chk({tx_lane_rate, rx_lane_rate}, {12'h0, RATE_HALF, RATE_QUARTER});
        @(posedge clk) {refclk_rate_select_hi, rate_override} <= 2'b01;
        settle();
        chk({tx_lane_rate, rx_lane_rate}, {12'h0, RATE_HALF, RATE_QUARTER});
        wr(16'h0007, 16'hdf07);
        chk({tx_lane_rate, rx_lane_rate}, {12'h0, RATE_FULL, RATE_FULL});
        @(posedge clk) auto_tx_rate <= RATE_FULL;
        wr(16'h0007, 16'hde06);
        chk({tx_lane_rate, rx_lane_rate}, {12'h0, RATE_QUARTER, RATE_QUARTER});
        wr(16'h0007, 16'hdc04);
        @(posedge clk) rate_override <= 1'b0;
    endtask

    task automatic t_polarity();
        @(posedge clk) {rx_lane_data, tx_in_pos, tx_in_neg} <= 12'ha35;
        settle();
        chk({rx_out_pos, rx_out_neg, tx_lane_data}, 16'h0a53);
        wr(16'h0008, 16'h800d);
        chk({rx_out_pos, rx_out_neg, tx_lane_data}, 16'h05a3);
        wr(16'h0008, 16'h4a0d);
        chk({rx_out_pos, rx_out_neg, tx_lane_data}, 16'h0a55);
        chk(16'(rx_equalizer_sel), 16'h000a);
        rd(5'h1e, 16'h0008, 16'h4a0d);
    endtask

    // writes outside the two mapped words must leave register b untouched; register c is not read back
    task automatic t_unmapped();
        access(1'b1, 5'h1e, 16'h0009, 16'hffff);
        access(1'b1, 5'h1f, 16'h0007, 16'h0000);
        rd(5'h1e, 16'h0009, 16'h0000);
        rd(5'h1f, 16'h0007, 16'h0000);
        rd(5'h1e, 16'h0007, 16'hdc04);
    endtask

    initial begin
        #(100 * 5000);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_swing();
        t_enable();
        t_rate();
        t_polarity();
        t_unmapped();
        close_out();
    end

endmodule // low_speed_serdes_lane_config_tb_top

`default_nettype wire
